// *** dda_pulse_pkg.sv ***
/*
  Constants, command layout and register map of the two-axis pulse generator.
  Assumes a 250 MHz system clock; every other rate is derived from it.
*/
// Behaviour
// - Each period lasts the programmed cycle value plus one, times a 1.024 ms base tick.
// - In every period each axis emits exactly its commanded count, capped at the top speed, equally spaced.
// - The per-period count takes any value from 0 to 2047, and 0 gives no pulses.
// - The cycle setting covers 1 to 254, so the longest period is 261.12 ms.
// - A move command drives both axes from one shared engine with common period bounds.
// - Commands enter a 2 Kbyte command queue and are executed in arrival order.
// - Each axis has a per-axis output form: 0 gives two direction lines, 1 gives pulse plus dir.
// - An axis moving toward an active limit stops at once and may only move away from it.
package dda_pulse_pkg;

  localparam int unsigned CLK_PERIOD_NS = 4;
  localparam int unsigned TICK_NS       = 1024000;                    // 1.024 ms
  localparam int unsigned TICK_CYCLES   = TICK_NS / CLK_PERIOD_NS;
  localparam int unsigned SUBTICKS      = 2048;                       // sub-ticks per period
  localparam int unsigned FIFO_BYTES    = 2048;
  localparam int unsigned FIFO_DEPTH    = FIFO_BYTES / 4;

  localparam int unsigned CNT_W = 11;
  localparam int unsigned CYC_W = 8;

  localparam logic [CYC_W-1:0] CYCLE_MIN   = 8'h01;
  localparam logic [CYC_W-1:0] CYCLE_MAX   = 8'hfe;
  localparam logic [CYC_W-1:0] CYCLE_RST   = 8'h01;
  localparam logic [CNT_W-1:0] HSPEED_RST  = 11'h7ff;
  localparam logic [CNT_W-1:0] LAST_SUB    = 11'h7ff;

  // register offsets (byte addresses)
  localparam logic [3:0] ADDR_CTRL   = 4'h0;
  localparam logic [3:0] ADDR_CMD    = 4'h4;
  localparam logic [3:0] ADDR_STATUS = 4'h8;
  localparam logic [3:0] ADDR_VARS   = 4'hc;

  // control register bits
  localparam int unsigned CTRL_XFORM = 0;
  localparam int unsigned CTRL_YFORM = 1;
  localparam int unsigned CTRL_NC    = 2;
  localparam int unsigned CTRL_CLR   = 3;
  localparam logic [2:0]  CTRL_RST   = 3'h0;

  // status register bits
  localparam int unsigned ST_EMPTY   = 0;
  localparam int unsigned ST_FULL    = 1;
  localparam int unsigned ST_BUSY    = 2;
  localparam int unsigned ST_XSTOP   = 3;
  localparam int unsigned ST_YSTOP   = 4;
  localparam int unsigned ST_OVR     = 5;
  localparam int unsigned ST_LVL_LO  = 16;

  // command word layout
  localparam int unsigned OP_LO      = 30;
  localparam logic [1:0]  OP_SETVAR  = 2'h0;
  localparam logic [1:0]  OP_MOVE    = 2'h1;
  localparam int unsigned SV_CYC_LO  = 0;
  localparam int unsigned SV_HS_LO   = 8;
  localparam int unsigned MV_XCNT_LO = 0;
  localparam int unsigned MV_XDIR    = 11;
  localparam int unsigned MV_YCNT_LO = 12;
  localparam int unsigned MV_YDIR    = 23;

  typedef enum logic {ENG_IDLE, ENG_RUN} eng_state_e;

  // a move never asks for more than the top speed set by software
  function automatic logic [CNT_W-1:0] clamp_count(input logic [CNT_W-1:0] cnt,
                                                   input logic [CNT_W-1:0] top);
    clamp_count = (cnt > top) ? top : cnt;
  endfunction

endpackage

// *** dda_axis_output.sv ***
/*
  One axis output stage: limit input conditioning, motion blocking toward an
  active limit, pulse stretching and the two output forms.
  Assumes step_i is a one-cycle pulse from the same clock, spaced wider than PULSE_W.
*/
`timescale 1ns/100ps
module dda_axis_output
  import dda_pulse_pkg::*;
#(
  parameter int unsigned PULSE_W = 62
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic step_i,
  input  wire logic dir_i,
  input  wire logic form_i,
  input  wire logic lim_nc_i,
  input  wire logic pos_limit_n_i,
  input  wire logic neg_limit_n_i,
  output wire logic line_a_o,
  output wire logic line_b_o,
  output wire logic stopped_o
);

  localparam int unsigned PW = $clog2(PULSE_W + 1);

  if (PULSE_W < 1) begin : g_chk
    $error("PULSE_W must be at least one cycle");
  end

  typedef struct packed {
    logic [1:0]    s1;
    logic [1:0]    s2;
    logic [1:0]    s3;
    logic [1:0]    pin;
    logic [PW-1:0] pcnt;
    logic          line_a;
    logic          line_b;
    logic          stopped;
  } axis_s;

  axis_s q;
  axis_s d;

  logic [1:0] act;
  logic       blocked;
  logic       pulse;

  always_comb begin
    d = q;
    d.s1 = {pos_limit_n_i, neg_limit_n_i};
    d.s2 = q.s1;
    d.s3 = q.s2;
    for (int i = 0; i < 2; i++) begin
      if (q.s2[i] == q.s3[i]) begin
        d.pin[i] = q.s2[i];
      end
    end
    // normal open switches pull low when hit, normal closed ones open high
    act = lim_nc_i ? q.pin : ~q.pin;
    // bit 1 is the positive limit, bit 0 the negative one
    blocked = dir_i ? act[1] : act[0];
    if (step_i && !blocked) begin
      d.pcnt = PW'(PULSE_W);
    end else if (q.pcnt != '0) begin
      d.pcnt = q.pcnt - 1'b1;
    end
    pulse = (d.pcnt != '0);
    d.stopped = blocked;
    if (form_i) begin
      d.line_a = pulse;
      d.line_b = dir_i;
    end else begin
      d.line_a = pulse && dir_i;
      d.line_b = pulse && !dir_i;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      q <= '{s1: 2'h3, s2: 2'h3, s3: 2'h3, pin: 2'h3, pcnt: '0,
             line_a: 1'b0, line_b: 1'b0, stopped: 1'b0};
    end else begin
      q <= d;
    end
  end

  assign line_a_o  = q.line_a;
  assign line_b_o  = q.line_b;
  assign stopped_o = q.stopped;

endmodule

// *** two_axis_dda_pulse_generator.sv ***
/*
  Two-axis pulse generator: command queue, shared period engine with
  per-axis adding accumulators, register port, and two axis output stages.
  Assumes a plain register master and motor drivers on the pulse lines.
*/
// Implementation choices: the register addresses and strobed register access.
`timescale 1ns/100ps
module two_axis_dda_pulse_generator
  import dda_pulse_pkg::*;
#(
  parameter int unsigned TICK_CYCLES_P = TICK_CYCLES,
  parameter int unsigned DEPTH         = FIFO_DEPTH
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic [3:0]  addr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output wire logic [31:0] rdata_o,
  input  wire logic        x_positive_limit_n_i,
  input  wire logic        x_negative_limit_n_i,
  input  wire logic        y_positive_limit_n_i,
  input  wire logic        y_negative_limit_n_i,
  output wire logic        x_line_a_o,
  output wire logic        x_line_b_o,
  output wire logic        y_line_a_o,
  output wire logic        y_line_b_o,
  output wire logic        busy_o
);

  localparam int unsigned SUB_BASE = TICK_CYCLES_P / SUBTICKS;
  localparam int unsigned BW       = $clog2(SUB_BASE);
  localparam int unsigned AW       = $clog2(DEPTH);
  localparam logic [BW-1:0] BASE_LAST = BW'(SUB_BASE - 1);

  // the divider only works in whole sub-ticks, and a pulse needs half of one
  if ((TICK_CYCLES_P % SUBTICKS) != 0) begin : g_chk_tick
    $error("tick length must be a whole number of sub-ticks");
  end
  if (SUB_BASE < 4) begin : g_chk_base
    $error("a sub-tick must last at least four clock cycles");
  end
  // pointers wrap by overflow, so the depth must be a power of two
  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk_depth
    $error("queue depth must be a power of two of at least two");
  end

  typedef struct packed {
    eng_state_e       st;
    logic [AW-1:0]    wr;
    logic [AW-1:0]    rd;
    logic [AW:0]      level;
    logic             head_vld;
    logic [2:0]       ctrl;
    logic             ovr;
    logic [CYC_W-1:0] cycle;
    logic [CNT_W-1:0] hspeed;
    logic [BW-1:0]    base;
    logic [CYC_W-1:0] pre;
    logic [CNT_W-1:0] idx;
    logic [CNT_W-1:0] acc_x;
    logic [CNT_W-1:0] acc_y;
    logic [CNT_W-1:0] cnt_x;
    logic [CNT_W-1:0] cnt_y;
    logic             dir_x;
    logic             dir_y;
    logic             step_x;
    logic             step_y;
    logic [31:0]      rdata;
  } gen_s;

  gen_s q;
  gen_s d;

  // op field of a queued command word
  function automatic logic [1:0] cmd_op(input logic [31:0] w);
    cmd_op = w[OP_LO +: 2];
  endfunction

  // one accumulator step; the carry out asks for one output pulse
  function automatic logic [CNT_W:0] acc_add(input logic [CNT_W-1:0] acc,
                                             input logic [CNT_W-1:0] cnt);
    acc_add = {1'b0, acc} + {1'b0, cnt};
  endfunction

  logic [31:0] mem [DEPTH];
  logic [31:0] head_q;
  logic        push;
  logic        pop;
  logic        sub_tick;
  logic        take_move;
  logic [CNT_W:0] sum_x;
  logic [CNT_W:0] sum_y;
  logic [CYC_W-1:0] new_cyc;
  logic        x_stop;
  logic        y_stop;
  logic [31:0] rmux;
  logic        fifo_full;
  logic        fifo_empty;

  // queue storage keeps no reset; only the pointers define its content
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[q.wr] <= wdata_i;
    end
    head_q <= mem[q.rd];
  end

  always_comb begin
    d = q;
    pop = 1'b0;
    take_move = 1'b0;
    sub_tick = 1'b0;
    sum_x = '0;
    sum_y = '0;
    new_cyc = head_q[SV_CYC_LO +: CYC_W];
    d.step_x = 1'b0;
    d.step_y = 1'b0;

    fifo_full = (q.level == (AW+1)'(DEPTH));
    fifo_empty = (q.level == '0);
    // a word written to a full queue is dropped, never written over the head
    push = wr_i && (addr_i == ADDR_CMD) && !fifo_full;

    // period engine: fixed divider, then a prescaler of cycle+1 base steps
    unique case (q.st)
      ENG_IDLE: begin
        d.base = '0;
        d.pre = '0;
        d.idx = '0;
        d.acc_x = '0;
        d.acc_y = '0;
        // unknown op codes are popped and dropped so the queue never stalls
        if (q.head_vld) begin
          pop = 1'b1;
          if (cmd_op(head_q) == OP_SETVAR) begin
            // a zero cycle or the reserved top value is clamped, not refused
            if (new_cyc < CYCLE_MIN) begin
              d.cycle = CYCLE_MIN;
            end else if (new_cyc > CYCLE_MAX) begin
              d.cycle = CYCLE_MAX;
            end else begin
              d.cycle = new_cyc;
            end
            d.hspeed = head_q[SV_HS_LO +: CNT_W];
          end else if (cmd_op(head_q) == OP_MOVE) begin
            take_move = 1'b1;
            d.st = ENG_RUN;
          end
        end
      end
      ENG_RUN: begin
        if (q.base == BASE_LAST) begin
          d.base = '0;
          if (q.pre == q.cycle) begin
            d.pre = '0;
            sub_tick = 1'b1;
          end else begin
            d.pre = q.pre + 1'b1;
          end
        end else begin
          d.base = q.base + 1'b1;
        end
        if (sub_tick) begin
          // the carry out of each accumulator marks one evenly placed pulse
          sum_x = acc_add(q.acc_x, q.cnt_x);
          sum_y = acc_add(q.acc_y, q.cnt_y);
          d.acc_x = sum_x[CNT_W-1:0];
          d.acc_y = sum_y[CNT_W-1:0];
          d.step_x = sum_x[CNT_W];
          d.step_y = sum_y[CNT_W];
          d.idx = q.idx + 1'b1;
          if (q.idx == LAST_SUB) begin
            // back-to-back moves share boundaries with no idle gap
            if (q.head_vld && cmd_op(head_q) == OP_MOVE) begin
              pop = 1'b1;
              take_move = 1'b1;
            end else begin
              d.st = ENG_IDLE;
              d.cnt_x = '0;
              d.cnt_y = '0;
            end
          end
        end
      end
    endcase

    if (take_move) begin
      d.cnt_x = clamp_count(head_q[MV_XCNT_LO +: CNT_W], q.hspeed);
      d.cnt_y = clamp_count(head_q[MV_YCNT_LO +: CNT_W], q.hspeed);
      d.dir_x = head_q[MV_XDIR];
      d.dir_y = head_q[MV_YDIR];
    end

    if (push) begin
      d.wr = q.wr + 1'b1;
    end
    if (pop) begin
      d.rd = q.rd + 1'b1;
    end
    d.level = q.level + (AW+1)'(push) - (AW+1)'(pop);
    // head word needs one cycle after any pointer move to be read back
    d.head_vld = (q.level != '0) && !pop && !q.head_vld ? 1'b1 : (q.head_vld && !pop);
    if (fifo_empty) begin
      d.head_vld = 1'b0;
    end

    if (wr_i && addr_i == ADDR_CTRL) begin
      d.ctrl = wdata_i[2:0];
      if (wdata_i[CTRL_CLR]) begin
        d.ovr = 1'b0;
      end
    end
    // an overflow in the same cycle as the clear is kept
    if (wr_i && addr_i == ADDR_CMD && !push) begin
      d.ovr = 1'b1;
    end

    // read data stay zero outside a read cycle, so a shared bus can or them
    rmux = '0;
    unique case (addr_i)
      ADDR_CTRL:   rmux[2:0] = q.ctrl;
      ADDR_STATUS: begin
        rmux[ST_EMPTY] = fifo_empty;
        rmux[ST_FULL] = fifo_full;
        rmux[ST_BUSY] = (q.st == ENG_RUN);
        rmux[ST_XSTOP] = x_stop;
        rmux[ST_YSTOP] = y_stop;
        rmux[ST_OVR] = q.ovr;
        rmux[ST_LVL_LO +: AW+1] = q.level;
      end
      ADDR_VARS:   rmux[CYC_W+CNT_W-1:0] = {q.hspeed, q.cycle};
      default:     rmux = '0;
    endcase
    d.rdata = rd_i ? rmux : '0;
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      q <= '{st:       ENG_IDLE,
             wr:       '0,
             rd:       '0,
             level:    '0,
             head_vld: 1'b0,
             ctrl:     CTRL_RST,
             ovr:      1'b0,
             cycle:    CYCLE_RST,
             hspeed:   HSPEED_RST,
             base:     '0,
             pre:      '0,
             idx:      '0,
             acc_x:    '0,
             acc_y:    '0,
             cnt_x:    '0,
             cnt_y:    '0,
             dir_x:    1'b0,
             dir_y:    1'b0,
             step_x:   1'b0,
             step_y:   1'b0,
             rdata:    '0};
    end else begin
      q <= d;
    end
  end

  // both axes pulse for half a sub-tick, so steps one sub-tick apart never merge
  dda_axis_output #(
    .PULSE_W (SUB_BASE / 2)
  ) u_x_axis (
    .clk_i         (clk_i),
    .rst_i         (rst_i),
    .step_i        (q.step_x),
    .dir_i         (q.dir_x),
    .form_i        (q.ctrl[CTRL_XFORM]),
    .lim_nc_i      (q.ctrl[CTRL_NC]),
    .pos_limit_n_i (x_positive_limit_n_i),
    .neg_limit_n_i (x_negative_limit_n_i),
    .line_a_o      (x_line_a_o),
    .line_b_o      (x_line_b_o),
    .stopped_o     (x_stop)
  );

  dda_axis_output #(
    .PULSE_W (SUB_BASE / 2)
  ) u_y_axis (
    .clk_i         (clk_i),
    .rst_i         (rst_i),
    .step_i        (q.step_y),
    .dir_i         (q.dir_y),
    .form_i        (q.ctrl[CTRL_YFORM]),
    .lim_nc_i      (q.ctrl[CTRL_NC]),
    .pos_limit_n_i (y_positive_limit_n_i),
    .neg_limit_n_i (y_negative_limit_n_i),
    .line_a_o      (y_line_a_o),
    .line_b_o      (y_line_b_o),
    .stopped_o     (y_stop)
  );

  assign rdata_o = q.rdata;
  assign busy_o  = (q.st == ENG_RUN);

endmodule

// *** dda_gen_properties.sv ***
/*
  Port-level checks of the two-axis pulse generator.
  Bound to the top module; sees only its ports.
*/
`timescale 1ns/100ps
module dda_gen_properties
  import dda_pulse_pkg::*;
#(
  parameter int unsigned TICK_CYCLES_P = TICK_CYCLES,
  parameter int unsigned DEPTH         = FIFO_DEPTH
) (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic [3:0]  addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic        wr_i,
  input wire logic        rd_i,
  input wire logic [31:0] rdata_o,
  input wire logic        x_positive_limit_n_i,
  input wire logic        x_negative_limit_n_i,
  input wire logic        y_positive_limit_n_i,
  input wire logic        y_negative_limit_n_i,
  input wire logic        x_line_a_o,
  input wire logic        x_line_b_o,
  input wire logic        y_line_a_o,
  input wire logic        y_line_b_o,
  input wire logic        busy_o
);
  logic [2:0]  ctrl_q;
  logic [7:0]  hi_q;
  logic [31:0] run_q;

  // shadow of the control bits, so form and readback can be judged
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl_q <= 3'h0;
      hi_q   <= 8'h0;
      run_q  <= 32'h0;
    end else begin
      if (wr_i && addr_i == ADDR_CTRL) begin
        ctrl_q <= wdata_i[2:0];
      end
      hi_q  <= x_line_a_o ? hi_q + 8'h1 : 8'h0;
      run_q <= busy_o ? run_q + 32'h1 : 32'h0;
    end
  end

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  rdata_idle_a: assert property (!$past(rd_i) |-> rdata_o == 32'h0)
    else $error("read data not zero outside a read");
  status_busy_a: assert property ($past(rd_i && addr_i == ADDR_STATUS) |->
    rdata_o[ST_BUSY] == $past(busy_o)) else $error("status busy bit wrong");
  vars_range_a: assert property ($past(rd_i && addr_i == ADDR_VARS) |->
    rdata_o[7:0] inside {[CYCLE_MIN:CYCLE_MAX]} && rdata_o[31:19] == 13'h0)
    else $error("cycle setting out of range");
  ctrl_back_a: assert property ($past(rd_i && addr_i == ADDR_CTRL) |->
    rdata_o == {29'h0, $past(ctrl_q)}) else $error("control readback wrong");
  pulse_width_a: assert property ($fell(x_line_a_o) |->
    hi_q == TICK_CYCLES_P / 4096) else $error("pulse width wrong");
  dual_line_a: assert property (!ctrl_q[CTRL_XFORM] |->
    !(x_line_a_o && x_line_b_o)) else $error("both direction lines high");
  period_len_a: assert property (!busy_o && run_q != 0 |->
    run_q % TICK_CYCLES_P == 0 && run_q >= 2 * TICK_CYCLES_P)
    else $error("period length wrong");
  pulse_busy_a: assert property ($rose(x_line_a_o) |->
    $past(busy_o) || $past(busy_o, 2)) else $error("pulse outside a period");

  cover property ($fell(busy_o));
  cover property ($fell(x_line_a_o));
  cover property ($past(rd_i && addr_i == ADDR_STATUS));
endmodule

bind two_axis_dda_pulse_generator dda_gen_properties #(
  .TICK_CYCLES_P(TICK_CYCLES_P),
  .DEPTH        (DEPTH)
) u_chk (
  .clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
  .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
  .x_positive_limit_n_i(x_positive_limit_n_i), .x_negative_limit_n_i(x_negative_limit_n_i),
  .y_positive_limit_n_i(y_positive_limit_n_i), .y_negative_limit_n_i(y_negative_limit_n_i),
  .x_line_a_o(x_line_a_o), .x_line_b_o(x_line_b_o), .y_line_a_o(y_line_a_o),
  .y_line_b_o(y_line_b_o), .busy_o(busy_o)
);

// *** dda_motor_driver.sv ***
/*
  Motor driver model: counts forward and reverse steps on one axis.
  Assumes the bench tells it the output form the generator uses.
*/
`timescale 1ns/100ps
module dda_motor_driver (
  input  wire logic        clk_i,
  input  wire logic        clr_i,
  input  wire logic        form_i,
  input  wire logic        line_a_i,
  input  wire logic        line_b_i,
  output logic      [15:0] fwd_o,
  output logic      [15:0] rev_o
);
  logic a_q = 1'b0;
  logic b_q = 1'b0;

  // steps are taken on rising edges; a held level is one step only
  always_ff @(posedge clk_i) begin
    a_q <= line_a_i;
    b_q <= line_b_i;
    if (clr_i) begin
      fwd_o <= 16'h0;
      rev_o <= 16'h0;
    end else if (line_a_i && !a_q && (!form_i || line_b_i)) begin
      fwd_o <= fwd_o + 16'h1;
    end else if (line_a_i && !a_q) begin
      rev_o <= rev_o + 16'h1;
    end else if (!form_i && line_b_i && !b_q) begin
      rev_o <= rev_o + 16'h1;
    end
  end
endmodule

// *** tb_top.sv ***
/*
  Self-checking bench of the pulse generator: register rows, then moves.
  Assumes a shortened base tick so whole periods fit in the run.
*/
`timescale 1ns/100ps
module tb_top;
  import dda_pulse_pkg::*;
  localparam int unsigned TK = 8192;
  typedef struct packed {logic w; logic [3:0] a; logic [31:0] d;} row_s;
  logic        clk_i   = 1'b0;
  logic        rst_i   = 1'b1;
  logic [3:0]  addr_i  = 4'h0;
  logic [31:0] wdata_i = 32'h0;
  logic        wr_i    = 1'b0;
  logic        rd_i    = 1'b0;
  logic [3:0]  lim_n   = 4'hf;
  logic [1:0]  form    = 2'h0;
  logic        clr     = 1'b0;
  logic [31:0] rdata_o;
  logic [31:0] got;
  logic        xa, xb, ya, yb, busy;
  logic [15:0] xf, xr, yf, yr;
  int          num_errors  = 0;
  int          checks_done = 0;
  int          cyc         = 0;
  // d is write data for writes and expected data for reads
  row_s        rows [10] = '{'{1'b0, 4'hc, 32'h0007ff01}, '{1'b0, 4'h8, 32'h1},
    '{1'b0, 4'h0, 32'h0}, '{1'b1, 4'h0, 32'hf}, '{1'b0, 4'h0, 32'h7},
    '{1'b1, 4'h8, 32'hffff}, '{1'b1, 4'hc, 32'h0}, '{1'b0, 4'hc, 32'h0007ff01},
    '{1'b0, 4'h2, 32'h0}, '{1'b1, 4'h0, 32'h0}};

  always #2 clk_i = ~clk_i;

  two_axis_dda_pulse_generator #(.TICK_CYCLES_P(TK), .DEPTH(FIFO_DEPTH)) dut (
    .clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .x_positive_limit_n_i(lim_n[0]),
    .x_negative_limit_n_i(lim_n[1]), .y_positive_limit_n_i(lim_n[2]),
    .y_negative_limit_n_i(lim_n[3]), .x_line_a_o(xa), .x_line_b_o(xb),
    .y_line_a_o(ya), .y_line_b_o(yb), .busy_o(busy));
  dda_motor_driver x_drv (.clk_i(clk_i), .clr_i(clr), .form_i(form[0]),
    .line_a_i(xa), .line_b_i(xb), .fwd_o(xf), .rev_o(xr));
  dda_motor_driver y_drv (.clk_i(clk_i), .clr_i(clr), .form_i(form[1]),
    .line_a_i(ya), .line_b_i(yb), .fwd_o(yf), .rev_o(yr));

  task automatic end_sim();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a);
    @(posedge clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 got = rdata_o;
  endtask

  // variables command, one move, then period length and step counts
  task automatic mv(input logic [31:0] sv, input logic [31:0] m, input int per,
                    input logic [63:0] e);
    int n = 0;
    clr <= 1'b1;
    wr(ADDR_CMD, sv);
    clr <= 1'b0;
    wr(ADDR_CMD, m);
    while (busy !== 1'b1 && n < 200) begin
      @(posedge clk_i);
      #1 n++;
    end
    n = 0;
    while (busy === 1'b1 && n < 40000) begin
      n++;
      @(posedge clk_i);
      #1;
    end
    chk("period", per, n);
    repeat (20) @(posedge clk_i);
    chk("x fwd", {16'h0, e[63:48]}, {16'h0, xf});
    chk("x rev", {16'h0, e[47:32]}, {16'h0, xr});
    chk("y fwd", {16'h0, e[31:16]}, {16'h0, yf});
    chk("y rev", {16'h0, e[15:0]}, {16'h0, yr});
  endtask

  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 90000) begin
      num_errors++;
      end_sim();
    end
  end

  initial begin
    repeat (20) @(posedge clk_i);
    chk("lines in reset", 32'h0, {27'h0, xa, xb, ya, yb, busy});
    chk("rdata in reset", 32'h0, rdata_o);
    rst_i <= 1'b0;
    foreach (rows[i]) begin
      if (rows[i].w) begin
        wr(rows[i].a, rows[i].d);
      end else begin
        rd(rows[i].a);
        chk("reg read", rows[i].d, got);
      end
    end
    mv(32'h0007ff01, {8'h40, 1'b0, 11'h7ff, 1'b1, 11'h3}, 2 * TK,
       {16'h3, 16'h0, 16'h0, 16'h7ff});
    wr(ADDR_CTRL, 32'h3);
    form <= 2'h3;
    mv(32'h0007ff01, {8'h40, 1'b1, 11'h5, 1'b0, 11'h0}, 2 * TK,
       {16'h0, 16'h0, 16'h5, 16'h0});
    chk("dir level", 32'h1, {31'h0, yb});
    wr(ADDR_CTRL, 32'h0);
    form <= 2'h0;
    // top speed 4 clamps the x count of 10 and leaves y at 4; cycle 2 stretches the period
    mv(32'h00000402, {8'h40, 1'b0, 11'h4, 1'b1, 11'ha}, 3 * TK,
       {16'h4, 16'h0, 16'h0, 16'h4});
    lim_n <= 4'ha;
    repeat (5) @(posedge clk_i);
    mv(32'h0007ff01, {8'h40, 1'b0, 11'h4, 1'b1, 11'h4}, 2 * TK,
       {16'h0, 16'h0, 16'h0, 16'h4});
    rd(ADDR_STATUS);
    chk("limit status", 32'h9, got);
    end_sim();
  end
endmodule
